// *** logic/frpc_map.vh ***
// Register offsets, field positions, reset values and timing for the flash row erase/program controller.
// Included by the controller only; the holding-register memory takes its sizes as parameters. Definitions only.
`ifndef FRPC_MAP_VH
`define FRPC_MAP_VH

// Register offsets on the 4-bit register port
`define FRPC_ADDR_W          4
`define FRPC_OFS_MEM_CTRL    4'h0
`define FRPC_OFS_UNLOCK_KEY  4'h1
`define FRPC_OFS_PTR_LOW     4'h2
`define FRPC_OFS_PTR_HIGH    4'h3
`define FRPC_OFS_PTR_UPPER   4'h4
`define FRPC_OFS_BYTE_LATCH  4'h5
`define FRPC_OFS_STATUS      4'h6
`define FRPC_OFS_TBL_STORE   4'h7
`define FRPC_OFS_HOLD_READ   4'h8

// memory_control_reg fields
`define FRPC_BIT_PROG_SPACE  7
`define FRPC_BIT_CFG_SPACE   6
`define FRPC_BIT_ROW_ERASE   4
`define FRPC_BIT_INTERRUPTED 3
`define FRPC_BIT_PERMIT      2
`define FRPC_BIT_LAUNCH      1

// Status register field
`define FRPC_BIT_DONE_FLAG   0

// Unlock key values
`define FRPC_KEY_FIRST       8'h55
`define FRPC_KEY_SECOND      8'hAA

// Table store pointer modes (low two bits of the store command)
`define FRPC_TS_KEEP         2'h0
`define FRPC_TS_POST_INC     2'h1
`define FRPC_TS_POST_DEC     2'h2
`define FRPC_TS_PRE_INC      2'h3

// Pointer geometry
`define FRPC_PTR_W           22
`define FRPC_ROW_LSB         6
`define FRPC_BLK_LSB         3
`define FRPC_HOLD_COUNT      8

// Reset values
`define FRPC_RST_BYTE        8'h00
`define FRPC_RST_PTR         22'h000000

// Timing: self-timed long write in ns, clock period in ns
`define FRPC_LONG_WRITE_NS   2000000
`define FRPC_CLK_NS          10

`endif

// *** logic/frpc_hold_mem.v ***
// Holding registers that collect table-store bytes before a program cycle.
// Assumes one clock; read data and the block snapshot come out of registers.
`timescale 1ns/100ps

module frpc_hold_mem #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire                   clk_sys,
	input  wire                   wr_en,
	input  wire [AW-1:0]          wr_addr,
	input  wire [WIDTH-1:0]       wr_data,
	input  wire [AW-1:0]          rd_addr,
	output reg  [WIDTH-1:0]       rd_data,
	input  wire                   snap_en,
	output reg  [WIDTH*DEPTH-1:0] snap_data
);

	reg     [WIDTH-1:0] mem [0:DEPTH-1];
	integer             i;

	// Short write touches only one holding register
	always @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

	// Whole block captured at once so the flash sees stable data for the long write
	always @(posedge clk_sys) begin
		if (snap_en) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				snap_data[i*WIDTH +: WIDTH] <= mem[i];
			end
		end
	end

endmodule

// *** logic/frpc_ctrl.v ***
// Flash row erase / block program controller: registers, unlock, holding registers and long-write timer.
// Assumes the CPU reaches it over a plain register port and freezes while cpu_stall is high,
// and that the flash array acts on the erase/program levels while they stand.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "frpc_map.vh"

module frpc_ctrl #(
	parameter LONG_WRITE_CYCLES = `FRPC_LONG_WRITE_NS / `FRPC_CLK_NS
) (
	input  wire                         clk_sys,
	input  wire                         por_resetn,
	input  wire                         resetn,
	input  wire [`FRPC_ADDR_W-1:0]      reg_addr,
	input  wire [7:0]                   reg_wdata,
	input  wire                         reg_wr,
	input  wire                         reg_rd,
	output wire [7:0]                   reg_rdata,
	output wire                         cpu_stall,
	output reg                          completion_irq_flag,
	output reg                          flash_erase,
	output reg                          flash_program,
	output reg  [15:0]                  flash_row_addr,
	output reg  [18:0]                  flash_blk_addr,
	output wire [63:0]                  flash_wdata
);

	localparam ST_IDLE = 2'h0;
	localparam ST_SNAP = 2'h1;
	localparam ST_RUN  = 2'h2;

	localparam KEY_NONE  = 2'h0;
	localparam KEY_FIRST = 2'h1;
	localparam KEY_ARMED = 2'h2;

	// Pointer operations only move the low 21 bits; bit 21 stays put
	function [`FRPC_PTR_W-1:0] ptr_step;
		input [`FRPC_PTR_W-1:0] ptr;
		input                   down;
		begin
			if (down) begin
				ptr_step = {ptr[21], ptr[20:0] - 21'h000001};
			end else begin
				ptr_step = {ptr[21], ptr[20:0] + 21'h000001};
			end
		end
	endfunction

	reg                    program_space_select;
	reg                    config_space_select;
	reg                    row_erase_select;
	reg                    interrupted_program_flag;
	reg                    erase_write_permit;
	reg                    launch;
	reg [`FRPC_PTR_W-1:0]  table_pointer;
	reg [7:0]              table_byte_latch;
	reg [1:0]              key_stage;
	reg [1:0]              state;
	reg                    op_erase;
	reg [31:0]             timer;
	reg [7:0]              rdata_q;
	reg                    rd_hold_q;

	reg [`FRPC_PTR_W-1:0]  next_table_pointer;
	reg [2:0]              hold_wr_addr;
	reg                    hold_wr_en;

	wire [7:0]             hold_rd_data;
	wire                   launch_req;
	wire                   timer_done;

	// CPU frozen for the whole long write, snapshot cycle included
	assign cpu_stall = (state != ST_IDLE);

	// Launch needs the armed key, and permit already set and set again in the same write; otherwise the set is refused
	assign launch_req = reg_wr && (reg_addr == `FRPC_OFS_MEM_CTRL) && reg_wdata[`FRPC_BIT_LAUNCH]
		&& (key_stage == KEY_ARMED) && reg_wdata[`FRPC_BIT_PERMIT] && erase_write_permit
		&& !launch && (state == ST_IDLE);

	// Apart from a reset, only the internal timer ends a long write
	assign timer_done = (state == ST_RUN) && (timer == 32'h00000001);

	assign reg_rdata = rd_hold_q ? hold_rd_data : rdata_q;

	// Table store: write target and pointer update for the four pointer modes
	always @* begin
		hold_wr_en = 1'b0;
		hold_wr_addr = table_pointer[2:0];
		next_table_pointer = table_pointer;
		if (reg_wr && (reg_addr == `FRPC_OFS_TBL_STORE) && (state == ST_IDLE)) begin
			hold_wr_en = 1'b1;
			case (reg_wdata[1:0])
				`FRPC_TS_POST_INC: begin
					next_table_pointer = ptr_step(table_pointer, 1'b0);
				end
				`FRPC_TS_POST_DEC: begin
					next_table_pointer = ptr_step(table_pointer, 1'b1);
				end
				`FRPC_TS_PRE_INC: begin
					next_table_pointer = ptr_step(table_pointer, 1'b0);
					hold_wr_addr = next_table_pointer[2:0];
				end
				default: begin
					next_table_pointer = table_pointer;
				end
			endcase
		end else if (reg_wr && (state == ST_IDLE)) begin
			if (reg_addr == `FRPC_OFS_PTR_LOW) begin
				next_table_pointer = {table_pointer[21:8], reg_wdata};
			end else if (reg_addr == `FRPC_OFS_PTR_HIGH) begin
				next_table_pointer = {table_pointer[21:16], reg_wdata, table_pointer[7:0]};
			end else if (reg_addr == `FRPC_OFS_PTR_UPPER) begin
				next_table_pointer = {reg_wdata[5:0], table_pointer[15:0]};
			end
		end
	end

	// Pointer, latch and selects; space selects survive a plain reset for error tracing
	always @(posedge clk_sys) begin
		if (!por_resetn) begin
			table_pointer <= `FRPC_RST_PTR;
			table_byte_latch <= `FRPC_RST_BYTE;
			program_space_select <= 1'b0;
			config_space_select <= 1'b0;
		end else if (!resetn) begin
			table_pointer <= `FRPC_RST_PTR;
			table_byte_latch <= `FRPC_RST_BYTE;
		end else begin
			table_pointer <= next_table_pointer;
			if (reg_wr && (reg_addr == `FRPC_OFS_BYTE_LATCH) && (state == ST_IDLE)) begin
				table_byte_latch <= reg_wdata;
			end
			if (reg_wr && (reg_addr == `FRPC_OFS_MEM_CTRL) && (state == ST_IDLE)) begin
				program_space_select <= reg_wdata[`FRPC_BIT_PROG_SPACE];
				config_space_select <= reg_wdata[`FRPC_BIT_CFG_SPACE];
			end
		end
	end

	// Unlock tracker: 55h then AAh on back-to-back writes, consumed by the very next write
	always @(posedge clk_sys) begin
		if (!por_resetn || !resetn) begin
			key_stage <= KEY_NONE;
		end else if (reg_wr) begin
			if ((reg_addr == `FRPC_OFS_UNLOCK_KEY) && (reg_wdata == `FRPC_KEY_FIRST)) begin
				key_stage <= KEY_FIRST;
			end else if ((reg_addr == `FRPC_OFS_UNLOCK_KEY) && (reg_wdata == `FRPC_KEY_SECOND)
				&& (key_stage == KEY_FIRST)) begin
				key_stage <= KEY_ARMED;
			end else begin
				key_stage <= KEY_NONE;
			end
		end
	end

	// Control bits: permit is plain, erase select clears when an erase ends, launch is set-only and clears when the write ends
	always @(posedge clk_sys) begin
		if (!por_resetn || !resetn) begin
			row_erase_select <= 1'b0;
			erase_write_permit <= 1'b0;
			launch <= 1'b0;
		end else begin
			if (reg_wr && (reg_addr == `FRPC_OFS_MEM_CTRL) && (state == ST_IDLE)) begin
				row_erase_select <= reg_wdata[`FRPC_BIT_ROW_ERASE];
				erase_write_permit <= reg_wdata[`FRPC_BIT_PERMIT];
			end else if (reg_wr && (reg_addr == `FRPC_OFS_MEM_CTRL)) begin
				erase_write_permit <= reg_wdata[`FRPC_BIT_PERMIT];
			end
			if (launch_req) begin
				launch <= 1'b1;
			end else if (timer_done) begin
				launch <= 1'b0;
			end
			if (timer_done && op_erase) begin
				row_erase_select <= 1'b0;
			end
		end
	end

	// A reset while the timer runs leaves the error flag set; only power-on clears it silently
	always @(posedge clk_sys) begin
		if (!por_resetn) begin
			interrupted_program_flag <= 1'b0;
		end else if (!resetn) begin
			if (state != ST_IDLE) begin
				interrupted_program_flag <= 1'b1;
			end
		end else if (reg_wr && (reg_addr == `FRPC_OFS_MEM_CTRL) && (state == ST_IDLE)) begin
			interrupted_program_flag <= reg_wdata[`FRPC_BIT_INTERRUPTED];
		end
	end

	// Completion flag: hardware set wins over a software clear in the same cycle
	always @(posedge clk_sys) begin
		if (!por_resetn || !resetn) begin
			completion_irq_flag <= 1'b0;
		end else if (timer_done) begin
			completion_irq_flag <= 1'b1;
		end else if (reg_wr && (reg_addr == `FRPC_OFS_STATUS) && !reg_wdata[`FRPC_BIT_DONE_FLAG]) begin
			completion_irq_flag <= 1'b0;
		end
	end

	// Long-write sequencer: snapshot the block for a program (none for an erase), then run the self timer
	always @(posedge clk_sys) begin
		if (!por_resetn || !resetn) begin
			state <= ST_IDLE;
			op_erase <= 1'b0;
			timer <= 32'h00000000;
			flash_erase <= 1'b0;
			flash_program <= 1'b0;
			flash_row_addr <= 16'h0000;
			flash_blk_addr <= 19'h00000;
		end else begin
			case (state)
				ST_IDLE: begin
					if (launch_req) begin
						state <= ST_SNAP;
						op_erase <= row_erase_select;
						// Erase addresses a whole row; low six pointer bits are dropped
						flash_row_addr <= table_pointer[21:`FRPC_ROW_LSB];
						// Program addresses an 8-byte block; low three bits are dropped
						flash_blk_addr <= table_pointer[21:`FRPC_BLK_LSB];
					end
				end
				ST_SNAP: begin
					state <= ST_RUN;
					timer <= LONG_WRITE_CYCLES;
					flash_erase <= op_erase;
					flash_program <= !op_erase;
				end
				ST_RUN: begin
					timer <= timer - 32'h00000001;
					if (timer_done) begin
						state <= ST_IDLE;
						flash_erase <= 1'b0;
						flash_program <= 1'b0;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Read data one cycle after the strobe; key port reads zero, unmapped offsets read zero
	always @(posedge clk_sys) begin
		if (!por_resetn || !resetn) begin
			rdata_q <= 8'h00;
			rd_hold_q <= 1'b0;
		end else begin
			rd_hold_q <= reg_rd && (reg_addr == `FRPC_OFS_HOLD_READ);
			rdata_q <= 8'h00;
			if (reg_rd) begin
				if (reg_addr == `FRPC_OFS_MEM_CTRL) begin
					rdata_q <= {program_space_select, config_space_select, 1'b0, row_erase_select,
						interrupted_program_flag, erase_write_permit, launch, 1'b0};
				end else if (reg_addr == `FRPC_OFS_PTR_LOW) begin
					rdata_q <= table_pointer[7:0];
				end else if (reg_addr == `FRPC_OFS_PTR_HIGH) begin
					rdata_q <= table_pointer[15:8];
				end else if (reg_addr == `FRPC_OFS_PTR_UPPER) begin
					rdata_q <= {2'h0, table_pointer[21:16]};
				end else if (reg_addr == `FRPC_OFS_BYTE_LATCH) begin
					rdata_q <= table_byte_latch;
				end else if (reg_addr == `FRPC_OFS_STATUS) begin
					rdata_q <= {7'h00, completion_irq_flag};
				end
			end
		end
	end

	// Holding registers; the byte latch feeds them and is never used by an erase
	frpc_hold_mem #(
		.WIDTH (8),
		.DEPTH (`FRPC_HOLD_COUNT),
		.AW    (3)
	) u_hold (
		.clk_sys   (clk_sys),
		.wr_en     (hold_wr_en),
		.wr_addr   (hold_wr_addr),
		.wr_data   (table_byte_latch),
		.rd_addr   (table_pointer[2:0]),
		.rd_data   (hold_rd_data),
		.snap_en   ((state == ST_SNAP) && !op_erase),
		.snap_data (flash_wdata)
	);

endmodule

// *** sim/frpc_ctrl_monitor.sv ***
// Port checker for the flash erase/program controller.
// Assumes it is bound to frpc_ctrl and sees only its ports.
`timescale 1ns/100ps
module frpc_monitor #(
	parameter LONG_WRITE_CYCLES = 20
) (
	input wire        clk_sys,
	input wire        por_resetn,
	input wire        resetn,
	input wire [3:0]  reg_addr,
	input wire [7:0]  reg_wdata,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [7:0]  reg_rdata,
	input wire        cpu_stall,
	input wire        completion_irq_flag,
	input wire        flash_erase,
	input wire        flash_program,
	input wire [15:0] flash_row_addr,
	input wire [18:0] flash_blk_addr,
	input wire [63:0] flash_wdata
);
	wire        busy = flash_erase | flash_program;
	wire        ctl_wr = reg_wr && reg_addr == 4'h0 && !cpu_stall;
	reg  [31:0] run_len;
	reg  [1:0]  key_stage;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn || !por_resetn);
	// Cycles the flash level has stood so far
	always @(posedge clk_sys) begin
		if (!resetn || !por_resetn)
			run_len <= 32'h0;
		else
			run_len <= busy ? run_len + 32'h1 : 32'h0;
	end
	// Unlock progress; any write but the next key restarts it
	always @(posedge clk_sys) begin
		if (!resetn || !por_resetn)
			key_stage <= 2'h0;
		else if (reg_wr)
			key_stage <= (reg_addr == 4'h1 && reg_wdata == 8'h55) ? 2'h1 :
				(reg_addr == 4'h1 && reg_wdata == 8'hAA && key_stage == 2'h1) ? 2'h2 : 2'h0;
	end
	a_stall_leads: assert property ($rose(cpu_stall) |=> busy)
		else $error("flash level did not follow the stall");
	a_flash_in_stall: assert property (busy |-> cpu_stall)
		else $error("flash level without stall");
	a_one_kind: assert property (!(flash_erase && flash_program))
		else $error("erase and program together");
	a_timer_len: assert property ($fell(busy) |-> run_len == LONG_WRITE_CYCLES)
		else $error("long write length wrong");
	a_timer_cap: assert property (busy |-> run_len < LONG_WRITE_CYCLES)
		else $error("long write overran its timer");
	a_done_at_end: assert property ($fell(busy) |-> completion_irq_flag && !cpu_stall)
		else $error("end of write not flagged");
	a_permit_gate: assert property (ctl_wr && reg_wdata[1] && !reg_wdata[2] |=> !cpu_stall)
		else $error("launch taken without permit");
	a_key_gate: assert property (ctl_wr && reg_wdata[1] && key_stage != 2'h2 |=> !cpu_stall)
		else $error("launch taken without unlock");
	a_addr_hold: assert property (busy && $past(busy) |-> $stable(flash_row_addr) && $stable(flash_blk_addr))
		else $error("flash address moved mid write");
endmodule

bind frpc_ctrl frpc_monitor #(.LONG_WRITE_CYCLES(LONG_WRITE_CYCLES)) frpc_monitor_i (.clk_sys, .por_resetn,
	.resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_stall, .completion_irq_flag,
	.flash_erase, .flash_program, .flash_row_addr, .flash_blk_addr, .flash_wdata);

// *** sim/frpc_cpu_model.sv ***
// CPU core model running firmware against the controller's register port.
// Assumes one clock; the core waits out a stall for at most 500 cycles, then issues anyway and raises hang.
`timescale 1ns/100ps
module frpc_cpu_model (
	input  wire       clk_sys,
	input  wire       cpu_stall,
	input  wire [7:0] reg_rdata,
	output reg  [3:0] reg_addr,
	output reg  [7:0] reg_wdata,
	output reg        reg_wr,
	output reg        reg_rd,
	output reg        hang
);
	initial begin
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		hang = 1'b0;
	end
	// One bus cycle; idle lines show the inverse so stale values never pass
	task issue(input w, input [3:0] a, input [7:0] d);
		integer i;
		begin
			i = 0;
			@(negedge clk_sys);
			while (cpu_stall && i < 500) begin
				@(negedge clk_sys);
				i = i + 1;
			end
			hang = hang | cpu_stall;
			@(posedge clk_sys);
			reg_wr <= w;
			reg_rd <= !w;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge clk_sys);
			reg_wr <= 1'b0;
			reg_rd <= 1'b0;
			reg_addr <= ~a;
			reg_wdata <= ~d;
		end
	endtask
	task wr(input [3:0] a, input [7:0] d);
		issue(1'b1, a, d);
	endtask
	// Read data stand only in the cycle after the strobe
	task rd(input [3:0] a, output [7:0] q);
		begin
			issue(1'b0, a, 8'h00);
			#1;
			q = reg_rdata;
		end
	endtask
	// Key writes back to back, then the launch write
	task launch(input [7:0] ctl);
		begin
			wr(4'h1, 8'h55);
			wr(4'h1, 8'hAA);
			wr(4'h0, ctl);
		end
	endtask
	// Eight latch-and-store pairs, pointer bumped before each store
	task load_block(input [63:0] blk);
		integer i;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				wr(4'h5, blk[8*i +: 8]);
				wr(4'h7, 8'h03);
			end
		end
	endtask
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the flash erase/program controller.
// Assumes a shortened long-write timer; the CPU model drives the register port.
`timescale 1ns/100ps
module tb_top;
	localparam N = 20;
	reg         clk_sys;
	reg         por_resetn;
	reg         resetn;
	reg         clr;
	reg  [7:0]  d;
	integer     n_mismatch, tests_run, n_stall, n_erase, n_prog;
	wire [3:0]  reg_addr;
	wire [7:0]  reg_wdata, reg_rdata;
	wire        reg_wr, reg_rd, cpu_stall, completion_irq_flag, flash_erase, flash_program, hang;
	wire [15:0] flash_row_addr;
	wire [18:0] flash_blk_addr;
	wire [63:0] flash_wdata;
	frpc_ctrl #(.LONG_WRITE_CYCLES(N)) frpc_ctrl_i (.clk_sys, .por_resetn, .resetn, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .cpu_stall, .completion_irq_flag, .flash_erase, .flash_program,
		.flash_row_addr, .flash_blk_addr, .flash_wdata);
	frpc_cpu_model frpc_cpu_model_i (.clk_sys, .cpu_stall, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .hang);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Cycle counts of stall and flash levels since the last clear
	always @(posedge clk_sys) begin
		if (clr) begin
			n_stall <= 0;
			n_erase <= 0;
			n_prog <= 0;
		end else begin
			n_stall <= n_stall + cpu_stall;
			n_erase <= n_erase + flash_erase;
			n_prog <= n_prog + flash_program;
		end
	end
	task stop_test;
		begin
			// A core that never got off the stall counts against the run
			if (hang !== 1'b0) begin
				n_mismatch = n_mismatch + 1;
			end
			$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
			if (n_mismatch == 0 && tests_run > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task check(input string what, input [63:0] seen, input [63:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("mismatch %s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	task rchk(input string what, input [3:0] a, input [7:0] exp);
		begin
			frpc_cpu_model_i.rd(a, d);
			check(what, d, exp);
		end
	endtask
	task wr(input [3:0] a, input [7:0] v);
		frpc_cpu_model_i.wr(a, v);
	endtask
	task zero;
		begin
			@(posedge clk_sys);
			clr <= 1'b1;
			@(posedge clk_sys);
			clr <= 1'b0;
		end
	endtask
	// Bounded wait for the long write to end
	task wait_idle;
		integer i;
		begin
			i = 0;
			@(negedge clk_sys);
			while (cpu_stall && i < 200) begin
				@(negedge clk_sys);
				i = i + 1;
			end
			if (cpu_stall || hang) begin
				n_mismatch = n_mismatch + 1;
				$display("mismatch stall end expected 0 seen 1");
				stop_test;
			end
		end
	endtask
	task t_reset;
		begin
			rchk("ctrl", 4'h0, 8'h00);
			rchk("status", 4'h6, 8'h00);
			rchk("key", 4'h1, 8'h00);
			rchk("unmapped", 4'hC, 8'h00);
			$display("test reset done");
		end
	endtask
	// Launch without key, with a broken key, and without permit
	task t_refuse;
		begin
			zero;
			wr(4'h0, 8'h84);
			wr(4'h0, 8'h86);
			rchk("no key", 4'h0, 8'h84);
			wr(4'h1, 8'h55);
			wr(4'h2, 8'h00);
			wr(4'h1, 8'hAA);
			wr(4'h0, 8'h86);
			rchk("broken key", 4'h0, 8'h84);
			wr(4'h0, 8'h80);
			frpc_cpu_model_i.launch(8'h82);
			rchk("no permit", 4'h0, 8'h80);
			check("refused stall", n_stall, 0);
			$display("test refuse done");
		end
	endtask
	task t_erase;
		begin
			wr(4'h2, 8'hFF);
			wr(4'h3, 8'h12);
			wr(4'h4, 8'h2A);
			wr(4'h5, 8'h5A); // junk latch must not matter
			zero;
			wr(4'h0, 8'h94);
			frpc_cpu_model_i.launch(8'h96);
			wait_idle;
			check("row", flash_row_addr, 22'h2A12FF >> 6);
			check("done pin", completion_irq_flag, 1'b1);
			check("erase len", n_erase, N);
			check("stall len", n_stall, N + 1);
			check("no program", n_prog, 0);
			rchk("ctrl after", 4'h0, 8'h84);
			rchk("done set", 4'h6, 8'h01);
			wr(4'h6, 8'h00);
			rchk("done clear", 4'h6, 8'h00);
			$display("test erase done");
		end
	endtask
	task t_program;
		begin
			wr(4'h2, 8'h3F);
			wr(4'h3, 8'h00);
			wr(4'h4, 8'h00);
			zero;
			frpc_cpu_model_i.load_block(64'h8877665544332211);
			check("short writes", n_prog, 0);
			wr(4'h0, 8'h84);
			frpc_cpu_model_i.launch(8'h86);
			wait_idle;
			check("block", flash_blk_addr, 19'h8);
			check("data", flash_wdata, 64'h8877665544332211);
			check("program len", n_prog, N);
			check("no erase", n_erase, 0);
			rchk("hold reg", 4'h8, 8'h88);
			wr(4'h7, 8'h02);
			rchk("post dec", 4'h2, 8'h46);
			wr(4'h7, 8'h00);
			rchk("keep", 4'h2, 8'h46);
			$display("test program done");
		end
	endtask
	// Reset in mid write must leave the error flag and the space select
	task t_abort;
		begin
			frpc_cpu_model_i.launch(8'h86);
			repeat (5) @(posedge clk_sys);
			resetn <= 1'b0;
			repeat (2) @(posedge clk_sys);
			resetn <= 1'b1;
			@(negedge clk_sys);
			check("aborted", {cpu_stall, flash_program}, 2'b00);
			rchk("error flag", 4'h0, 8'h88);
			$display("test abort done");
		end
	endtask
	// Full row update: one erase, then eight block programs across the row
	task t_row;
		integer k;
		begin
			wr(4'h2, 8'h40);
			wr(4'h0, 8'h94);
			frpc_cpu_model_i.launch(8'h96);
			wait_idle;
			check("row erase", flash_row_addr, 16'h0001);
			wr(4'h2, 8'h3F);
			for (k = 0; k < 8; k = k + 1) begin
				frpc_cpu_model_i.load_block({8{k[7:0]}});
				wr(4'h0, 8'h84);
				frpc_cpu_model_i.launch(8'h86);
				wait_idle;
				check("row block", flash_blk_addr, 19'h8 + k);
				check("row data", flash_wdata, {8{k[7:0]}});
			end
			$display("test row done");
		end
	endtask
	initial begin
		por_resetn = 1'b0;
		resetn = 1'b0;
		clr = 1'b1;
		n_mismatch = 0;
		tests_run = 0;
		repeat (2) @(posedge clk_sys);
		por_resetn <= 1'b1;
		resetn <= 1'b1;
		clr <= 1'b0;
		t_reset;
		t_refuse;
		t_erase;
		t_program;
		t_abort;
		t_row;
		stop_test;
	end
endmodule
